// ### include/bbx_pkg.sv
// Package: opcode fields, encodings and file addresses for the byte/bit execution unit
package bbx_pkg;

   localparam int unsigned OPC_W      = 14;
   localparam int unsigned ADDR_W     = 7;
   localparam int unsigned DATA_W     = 8;

   // Field positions
   localparam int unsigned TOP_HI     = 13;
   localparam int unsigned TOP_LO     = 12;
   localparam int unsigned NIB_HI     = 11;
   localparam int unsigned NIB_LO     = 8;
   localparam int unsigned DEST_BIT   = 7;
   localparam int unsigned BOP_HI     = 11;
   localparam int unsigned BOP_LO     = 10;
   localparam int unsigned BIDX_HI    = 9;
   localparam int unsigned BIDX_LO    = 7;
   localparam int unsigned LITOP_HI   = 11;
   localparam int unsigned LITOP_LO   = 8;

   // Encodings
   localparam logic [1:0] TOP_BYTE    = 2'h0;
   localparam logic [1:0] TOP_BIT     = 2'h1;
   localparam logic [1:0] TOP_LIT     = 2'h3;
   localparam logic [3:0] NIB_ADD_FILE = 4'h7;
   localparam logic [3:0] NIB_AND_FILE = 4'h5;
   localparam logic [1:0] BOP_CLR     = 2'h0;
   localparam logic [1:0] BOP_SET     = 2'h1;
   localparam logic [1:0] BOP_SKZ     = 2'h2;
   localparam logic [1:0] BOP_SK1     = 2'h3;
   localparam logic [2:0] LIT_ADD_HI  = 3'h7;
   localparam logic [3:0] LIT_AND     = 4'h9;

   // Status bit positions
   localparam int unsigned ST_C       = 0;
   localparam int unsigned ST_DIGC    = 1;
   localparam int unsigned ST_Z       = 2;

   // Special file addresses and reset values
   localparam logic [6:0] ADDR_TIMER  = 7'h01;
   localparam logic [6:0] ADDR_PORT   = 7'h05;
   localparam logic [7:0] ACC_RST     = 8'h00;
   localparam logic [2:0] FLAGS_RST   = 3'h0;

   typedef enum logic [0:0] {
      BBX_EXEC = 1'b0,
      BBX_NOP  = 1'b1
   } bbx_phase_t;

   typedef struct packed {
      bbx_phase_t  phase;
      logic [7:0]  acc;
      logic [2:0]  flags;
      logic        fwr;
      logic [6:0]  faddr;
      logic [7:0]  fdata;
      logic        pclr;
      logic        flush;
   } bbx_state_t;

   typedef struct packed {
      logic        valid;
      logic [13:0] word;
   } bbx_instr_t;

endpackage

// ### rtl/bbx_exec.sv
// Execution unit for literal/file add and AND, bit set/clear and bit-test-skip
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module bbx_exec
   import bbx_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_arst_n,
   input  wire bbx_instr_t  i_instr,
   input  wire logic [7:0]  i_file_rdata,
   input  wire logic [7:0]  i_port_pins,
   input  wire logic        i_psa_timer,
   output logic [6:0]       o_file_addr,
   output logic             o_file_we,
   output logic [6:0]       o_file_waddr,
   output logic [7:0]       o_file_wdata,
   output logic [7:0]       o_acc,
   output logic [2:0]       o_flags,
   output logic             o_presc_clr,
   output logic             o_flush,
   output logic             o_busy
);

   bbx_state_t s_q;
   bbx_state_t s_d;
   logic [7:0] pins_m_q;
   logic [7:0] pins_q;

   // Pins come from outside the clock domain
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pins_m_q <= 8'h00;
         pins_q   <= 8'h00;
      end else begin
         pins_m_q <= i_port_pins;
         pins_q   <= pins_m_q;
      end
   end

   logic [1:0] top;
   logic [3:0] nib;
   logic       dest;
   logic [1:0] bop;
   logic [2:0] bidx;
   logic [6:0] faddr;
   logic [7:0] lit;
   logic [7:0] fval;
   logic [7:0] bmask;
   logic [4:0] lo_sum;
   logic [8:0] sum;
   logic [7:0] addend;
   logic       is_add;
   logic       is_and;
   logic       is_lit;
   logic       to_file;
   logic [7:0] res;

   assign top   = i_instr.word[TOP_HI:TOP_LO];
   assign nib   = i_instr.word[NIB_HI:NIB_LO];
   assign dest  = i_instr.word[DEST_BIT];
   assign bop   = i_instr.word[BOP_HI:BOP_LO];
   assign bidx  = i_instr.word[BIDX_HI:BIDX_LO];
   assign faddr = i_instr.word[ADDR_W-1:0];
   assign lit   = i_instr.word[DATA_W-1:0];
   assign bmask = 8'h01 << bidx;

   assign o_file_addr = faddr;
   // Port reads see the pins so rewrites reflect externally driven levels
   assign fval = (faddr == ADDR_PORT) ? pins_q : i_file_rdata;

   always_comb begin
      is_lit = (top == TOP_LIT);
      is_add = (is_lit && nib[3:1] == LIT_ADD_HI) || (top == TOP_BYTE && nib == NIB_ADD_FILE);
      is_and = (is_lit && nib == LIT_AND) || (top == TOP_BYTE && nib == NIB_AND_FILE);
      addend = is_lit ? lit : fval;
      lo_sum = {1'b0, s_q.acc[3:0]} + {1'b0, addend[3:0]};
      sum    = {1'b0, s_q.acc} + {1'b0, addend};
      res    = is_add ? sum[7:0] : (s_q.acc & addend);
      to_file = !is_lit && dest;
   end

   always_comb begin
      s_d       = s_q;
      s_d.fwr   = 1'b0;
      s_d.pclr  = 1'b0;
      s_d.flush = 1'b0;
      s_d.faddr = faddr;
      s_d.fdata = fval;
      unique case (s_q.phase)
         BBX_NOP: begin
            // Fetched word is the discarded one; run nothing
            s_d.phase = BBX_EXEC;
         end
         BBX_EXEC: begin
            if (i_instr.valid) begin
               if (is_add || is_and) begin
                  if (to_file) begin
                     s_d.fwr   = 1'b1;
                     s_d.fdata = res;
                  end else begin
                     s_d.acc = res;
                  end
                  s_d.flags[ST_Z] = (res == 8'h00);
                  if (is_add) begin
                     s_d.flags[ST_C]  = sum[8];
                     s_d.flags[ST_DIGC] = lo_sum[4];
                  end
               end else if (top == TOP_BIT) begin
                  unique case (bop)
                     BOP_CLR: begin
                        s_d.fwr   = 1'b1;
                        s_d.fdata = fval & ~bmask;
                     end
                     BOP_SET: begin
                        s_d.fwr   = 1'b1;
                        s_d.fdata = fval | bmask;
                     end
                     BOP_SKZ: begin
                        if (fval[bidx] == 1'b0) begin
                           s_d.phase = BBX_NOP;
                           s_d.flush = 1'b1;
                        end
                     end
                     BOP_SK1: begin
                        if (fval[bidx] == 1'b1) begin
                           s_d.phase = BBX_NOP;
                           s_d.flush = 1'b1;
                        end
                     end
                  endcase
               end
               // Timer count writes restart the shared prescaler only while i_psa_timer is set
               if (s_d.fwr && faddr == ADDR_TIMER && i_psa_timer) begin
                  s_d.pclr = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_q <= '{phase: BBX_EXEC, acc: ACC_RST, flags: FLAGS_RST, fwr: 1'b0,
                  faddr: 7'h00, fdata: 8'h00, pclr: 1'b0, flush: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_file_we    = s_q.fwr;
   assign o_file_waddr = s_q.faddr;
   assign o_file_wdata = s_q.fdata;
   assign o_acc        = s_q.acc;
   assign o_flags      = s_q.flags;
   assign o_presc_clr  = s_q.pclr;
   assign o_flush      = s_q.flush;
   assign o_busy       = (s_q.phase == BBX_NOP);

   // Checks
   skip_one_nop_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s_q.phase == BBX_EXEC && i_instr.valid && top == TOP_BIT && bop == BOP_SK1 && fval[bidx])
      |=> (o_busy && o_flush) ##1 !o_busy)
      else $error("skip on one did not insert a single nop");
   skip_zero_nop_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s_q.phase == BBX_EXEC && i_instr.valid && top == TOP_BIT && bop == BOP_SKZ && !fval[bidx])
      |=> o_busy ##1 !o_busy)
      else $error("skip on zero did not insert a single nop");
   nop_keeps_state_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      o_busy |=> (!o_file_we && $stable(o_acc) && $stable(o_flags)))
      else $error("second skip cycle changed state");
   add_lit_acc_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s_q.phase == BBX_EXEC && i_instr.valid && is_lit && is_add)
      |=> (o_acc == 8'($past(s_q.acc) + $past(lit))) && o_flags[ST_C] == $past(sum[8]))
      else $error("add literal result wrong");
   add_file_dest_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s_q.phase == BBX_EXEC && i_instr.valid && top == TOP_BYTE && nib == NIB_ADD_FILE && dest)
      |=> o_file_we && $stable(o_acc))
      else $error("add file with d set did not write file");
   and_lit_flags_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s_q.phase == BBX_EXEC && i_instr.valid && is_lit && is_and)
      |=> o_flags[1:0] == $past(s_q.flags[1:0]) && o_flags[ST_Z] == (o_acc == 8'h00))
      else $error("and literal flags wrong");
   and_file_acc_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s_q.phase == BBX_EXEC && i_instr.valid && top == TOP_BYTE && nib == NIB_AND_FILE && !dest)
      |=> !o_file_we && o_acc == ($past(s_q.acc) & $past(fval)))
      else $error("and file to accumulator wrong");
   bit_clear_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s_q.phase == BBX_EXEC && i_instr.valid && top == TOP_BIT && bop == BOP_CLR)
      |=> o_file_we && !o_file_wdata[$past(bidx)] && $stable(o_flags))
      else $error("bit clear wrong");
   bit_set_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s_q.phase == BBX_EXEC && i_instr.valid && top == TOP_BIT && bop == BOP_SET)
      |=> o_file_we && o_file_wdata[$past(bidx)] && $stable(o_flags))
      else $error("bit set wrong");
   presc_clear_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (o_file_we && o_file_waddr == ADDR_TIMER && $past(i_psa_timer)) |-> o_presc_clr)
      else $error("timer write left prescaler running");
   presc_only_timer_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      o_presc_clr |-> (o_file_we && o_file_waddr == ADDR_TIMER))
      else $error("prescaler cleared without a timer write");
   flush_with_busy_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      o_flush |-> o_busy)
      else $error("flush pulse outside the nop cycle");
   add_file_zero_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s_q.phase == BBX_EXEC && i_instr.valid && top == TOP_BYTE && nib == NIB_ADD_FILE)
      |=> o_flags[ST_Z] == (8'($past(s_q.acc) + $past(fval)) == 8'h00))
      else $error("add file zero flag wrong");
   // Pins reach the datapath two edges late through the synchroniser
   port_pin_and_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s_q.phase == BBX_EXEC && i_instr.valid && top == TOP_BYTE && nib == NIB_AND_FILE
       && dest && faddr == ADDR_PORT)
      |=> o_file_wdata == ($past(s_q.acc) & $past(i_port_pins, 3)))
      else $error("port rewrite did not use pin levels");

endmodule

// ### tb/bbx_exec_tb.sv
// Self-checking bench for the byte/bit execution unit
`timescale 1ns/1ps
module bbx_exec_tb;
   import bbx_pkg::*;
   logic       i_mclk = 1'b0;
   logic       i_arst_n = 1'b0;
   bbx_instr_t instr = '0;
   logic [7:0] rdata = 8'h00;
   logic [7:0] pins = 8'hFF;
   logic       psa = 1'b0;
   logic [6:0] o_file_addr, o_file_waddr;
   logic [7:0] o_file_wdata, o_acc;
   logic [2:0] o_flags;
   logic       o_file_we, o_presc_clr, o_flush, o_busy;
   int         err_count = 0;
   int         check_count = 0;

   always #5 i_mclk = ~i_mclk;

   bbx_exec u_dut (
      .i_mclk       (i_mclk),
      .i_arst_n     (i_arst_n),
      .i_instr      (instr),
      .i_file_rdata (rdata),
      .i_port_pins  (pins),
      .i_psa_timer  (psa),
      .o_file_addr  (o_file_addr),
      .o_file_we    (o_file_we),
      .o_file_waddr (o_file_waddr),
      .o_file_wdata (o_file_wdata),
      .o_acc        (o_acc),
      .o_flags      (o_flags),
      .o_presc_clr  (o_presc_clr),
      .o_flush      (o_flush),
      .o_busy       (o_busy)
   );

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic tally_and_finish;
      if (err_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // One instruction, then its registered answer one edge later
   task automatic issue(input logic [13:0] w, input logic [7:0] rd, input logic [7:0] ea,
                        input logic [2:0] ef, input logic ewe, input logic [7:0] ewd,
                        input logic epc);
      @(posedge i_mclk);
      instr <= '{valid: 1'b1, word: w};
      rdata <= rd;
      @(posedge i_mclk);
      instr.valid <= 1'b0;
      #1;
      chk8("acc", ea, o_acc);
      chk8("flags", {5'h00, ef}, {5'h00, o_flags});
      chk1("file_we", ewe, o_file_we);
      chk1("presc_clr", epc, o_presc_clr);
      chk8("faddr", {1'b0, w[6:0]}, {1'b0, o_file_addr});
      if (ewe) begin
         chk8("wdata", ewd, o_file_wdata);
         chk8("waddr", {1'b0, w[6:0]}, {1'b0, o_file_waddr});
      end
   endtask

   // Bit test followed at once by add-literal 1; a taken skip must swallow it
   task automatic skip_case(input logic [1:0] op, input logic [2:0] b, input logic [7:0] rd,
                            input logic tk, input logic [7:0] a, input logic [2:0] f);
      @(posedge i_mclk);
      instr <= '{valid: 1'b1, word: {2'b01, op, b, 7'h22}};
      rdata <= rd;
      @(posedge i_mclk);
      instr <= '{valid: 1'b1, word: 14'h3E01};
      rdata <= 8'h00;
      #1;
      chk1("busy", tk, o_busy);
      chk1("flush", tk, o_flush);
      chk8("flags", {5'h00, f}, {5'h00, o_flags});
      @(posedge i_mclk);
      instr.valid <= 1'b0;
      #1;
      chk1("busy_end", 1'b0, o_busy);
      chk8("acc", tk ? a : a + 8'h01, o_acc);
   endtask

   task automatic bit_ops;
      for (int b = 0; b < 8; b++) begin
         issue({4'h5, b[2:0], 7'h22}, 8'h00, 8'h08, 3'h3, 1'b1, 8'h01 << b, 1'b0);
         issue({4'h4, b[2:0], 7'h22}, 8'hFF, 8'h08, 3'h3, 1'b1, ~(8'h01 << b), 1'b0);
      end
   endtask

   initial begin
      repeat (8) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      #1;
      chk8("acc_rst", 8'h00, o_acc);
      issue(14'h3EFF, 8'h00, 8'hFF, 3'h0, 1'b0, 8'h00, 1'b0);
      issue(14'h3E01, 8'h00, 8'h00, 3'h7, 1'b0, 8'h00, 1'b0);
      issue(14'h0720, 8'h38, 8'h38, 3'h0, 1'b0, 8'h00, 1'b0);
      issue(14'h07A0, 8'hC8, 8'h38, 3'h7, 1'b1, 8'h00, 1'b0);
      issue(14'h390F, 8'h00, 8'h08, 3'h3, 1'b0, 8'h00, 1'b0);
      issue(14'h05A1, 8'hF0, 8'h08, 3'h7, 1'b1, 8'h00, 1'b0);
      issue(14'h0521, 8'h0C, 8'h08, 3'h3, 1'b0, 8'h00, 1'b0);
      issue(14'h0900, 8'h00, 8'h08, 3'h3, 1'b0, 8'h00, 1'b0);
      bit_ops();
      psa <= 1'b1;
      issue(14'h1401, 8'h00, 8'h08, 3'h3, 1'b1, 8'h01, 1'b1);
      issue(14'h0581, 8'hFF, 8'h08, 3'h3, 1'b1, 8'h08, 1'b1);
      issue(14'h0501, 8'hFF, 8'h08, 3'h3, 1'b0, 8'h00, 1'b0);
      psa <= 1'b0;
      issue(14'h1401, 8'h00, 8'h08, 3'h3, 1'b1, 8'h01, 1'b0);
      // Pins pass a two-flop synchroniser, so settle them first
      pins <= 8'h00;
      repeat (3) @(posedge i_mclk);
      issue(14'h0585, 8'hFF, 8'h08, 3'h7, 1'b1, 8'h00, 1'b0);
      pins <= 8'h0F;
      repeat (3) @(posedge i_mclk);
      issue(14'h0585, 8'h00, 8'h08, 3'h3, 1'b1, 8'h08, 1'b0);
      skip_case(2'h3, 3'h2, 8'h04, 1'b1, 8'h08, 3'h3);
      skip_case(2'h2, 3'h2, 8'h04, 1'b0, 8'h08, 3'h3);
      skip_case(2'h2, 3'h5, 8'h00, 1'b1, 8'h09, 3'h0);
      skip_case(2'h3, 3'h5, 8'h00, 1'b0, 8'h09, 3'h0);
      tally_and_finish();
   end

   initial begin
      #100us;
      err_count++;
      tally_and_finish();
   end
endmodule
